// file: sim/ddr_memory_command_decoder_tb.sv
module ddr_memory_command_decoder_tb
  import cmd_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              req_valid, req_ready, rd_valid, illegal_seen;
  cmd_t              req_cmd;
  logic [BANK_W-1:0] req_bank, last_refresh_bank;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, rd_data, q, d, exp;
  logic [MASK_W-1:0] req_mask;
  logic [MODE_W-1:0] mode_word;
  logic [2:0]        busy_banks_cnt;
  logic [ROW_W-1:0]  last_refresh_row;
  int                err_count = 0;
  int                check_count = 0;

  always #5 clk = ~clk;  // Fixed period, never drifts

  mem_cmd_if link();
  mem_cmd_device u_mem_cmd_device (.clk(clk), .reset(reset), .link(link),
    .mode_word(mode_word), .busy_banks_cnt(busy_banks_cnt), .illegal_seen(illegal_seen),
    .last_refresh_row(last_refresh_row), .last_refresh_bank(last_refresh_bank));
  // Short refresh period so groups land inside the run
  mem_cmd_controller #(.REFRESH_CYC(40)) u_mem_cmd_controller (.clk(clk), .reset(reset),
    .link(link), .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_mask(req_mask),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid));
  mem_cmd_props u_mem_cmd_props (.clk(clk), .reset(reset), .sel_n(link.sel_n),
    .write_n(link.write_n), .refresh_n(link.refresh_n),
    .bank_select(link.bank_select), .rvalid(link.rvalid));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] ex);
    check_count++;
    if (seen !== ex) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, ex, seen);
    end
  endtask

  // Request held until the controller reports it issued
  task automatic request(input cmd_t c, input logic [2:0] b, input logic [20:0] a,
                         input logic [35:0] dw, input logic [1:0] m);
    int n;
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_bank  <= b;
    req_addr  <= a;
    req_wdata <= dw;
    req_mask  <= m;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    req_valid <= 1'b0;
    chk("req_ready", req_ready, 1'b1);
  endtask

  // Request, then a quiet stretch that lets any burst drain
  task automatic issue(input cmd_t c, input logic [2:0] b, input logic [20:0] a,
                       input logic [35:0] dw, input logic [1:0] m);
    request(c, b, a, dw, m);
    repeat (8) @(posedge clk);
  endtask

  // First word of a read burst; watched right after the request, since
  // each read word stands for one cycle only
  task automatic rd_word(input logic [2:0] b, output logic [35:0] w);
    int n;
    request(read_cmd, b, 21'h0_0003, 36'h0_0000_0000, 2'h0);
    n = 0;
    while (rd_valid !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    w = rd_data;
    chk("rd_valid", rd_valid, 1'b1);
  endtask

  task automatic summarize;
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    req_valid = 1'b0;
    req_cmd   = deselect_idle_cmd;
    req_bank  = 3'h0;
    req_addr  = 21'h0_0000;
    req_wdata = 36'h0_0000_0000;
    req_mask  = 2'h3;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (14) @(posedge clk);
    chk("refresh_bank", last_refresh_bank, 3'h7);
    chk("illegal_seen", illegal_seen, 1'b0);
    $display("Test refresh group done");
    // High address bits and bank must not reach the mode word
    issue(config_load_cmd, 3'h6, 21'h1C_0008, 36'h0_0000_0000, 2'h0);
    chk("mode_word", mode_word, 18'h0_0008);
    $display("Test mode load done");
    // Every mask code, each result read back
    for (int i = 0; i < 4; i++) begin
      d = {9{4'(i + 1)}};
      issue(write_cmd, 3'h5, 21'h0_0003, d, 2'(i));
      if (i % 2 == 0) exp[17:0] = d[17:0];
      if (i < 2) exp[35:18] = d[35:18];
      rd_word(3'h5, q);
      chk("stored_word", q, exp);
    end
    $display("Test write mask done");
    issue(write_cmd, 3'h2, 21'h0_0003, 36'h0_0000_0000, 2'h0);
    rd_word(3'h5, q);
    chk("other_bank", q, exp);
    repeat (60) @(posedge clk);
    chk("mode_kept", mode_word, 18'h0_0008);
    chk("busy_idle", busy_banks_cnt, 3'h0);
    chk("row_advanced", last_refresh_row != 13'h0000, 1'b1);
    $display("Test bank and idle done");
    // Mode load right behind a read must wait for the burst to drain
    rd_word(3'h5, q);
    chk("first_word", q, exp);
    issue(config_load_cmd, 3'h1, 21'h1C_0010, 36'h0_0000_0000, 2'h0);
    chk("mode_bl8", mode_word, 18'h0_0010);
    rd_word(3'h5, q);
    chk("bl8_word", q, exp);
    $display("Test mode reload done");
    summarize;
  end

  // Run takes well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("BAD watchdog expected done seen hang");
    summarize;
  end
endmodule // ddr_memory_command_decoder_tb

// file: sim/mem_cmd_props.sv
module mem_cmd_props
  import cmd_decode_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              sel_n,
  input wire logic              write_n,
  input wire logic              refresh_n,
  input wire logic [BANK_W-1:0] bank_select,
  input wire logic              rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Decoded strobes and helpers
  // ----------------------------------------------------------------
  wire logic  rd_c  = !sel_n && write_n && refresh_n;
  wire logic  wr_c  = !sel_n && !write_n && refresh_n;
  wire logic  cfg_c = !sel_n && !write_n && !refresh_n;
  wire logic  ref_c = !sel_n && write_n && !refresh_n;
  logic [3:0] since_rd_reg;  // Cycles since last read, saturating
  logic       first_reg;     // No command seen since reset

  // Saturation keeps a long idle stretch from wrapping into range
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      since_rd_reg <= 4'hF;
      first_reg    <= 1'b1;
    end else begin
      since_rd_reg <= rd_c ? 4'h1 : since_rd_reg + {3'h0, since_rd_reg != 4'hF};
      first_reg    <= first_reg && sel_n;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // First read word is registered one edge after the command edge
  a_read_burst_out: assert property (rd_c |-> ##2 rvalid [*2])
    else $error("read gave no burst");
  // An eight-word burst shows its last word nine edges after its command
  a_rvalid_cause: assert property (rvalid |-> since_rd_reg <= 4'h9)
    else $error("read word without a read");
  a_settle_quiet: assert property (cfg_c |=> sel_n [*5])
    else $error("command inside settle time");
  a_refresh_group: assert property (ref_c && !$past(ref_c) |-> ref_c [*8])
    else $error("refresh group short");
  a_bank_step: assert property (ref_c && $past(ref_c) |->
    bank_select == $past(bank_select) + 3'h1)
    else $error("refresh bank order");
  a_access_gap: assert property ((rd_c || wr_c) |=> (!(rd_c || wr_c)) [*3])
    else $error("accesses too close");
  a_first_refresh: assert property (!sel_n && first_reg |-> ref_c)
    else $error("first command not refresh");
  a_mode_idle: assert property (cfg_c |-> !rvalid)
    else $error("mode load during read");
  c_read: cover property (rd_c);
  c_write: cover property (wr_c);
  c_mode: cover property (cfg_c);
  c_group: cover property (ref_c ##1 ref_c);
endmodule // mem_cmd_props

// file: src/cmd_decode_pkg.sv
package cmd_decode_pkg;
  // ----------------------------------------------------------------
  // Link widths
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 21;     // Address field, bits 0..20
  localparam int BANK_W      = 3;      // Eight banks
  localparam int MODE_W      = 18;     // Mode word, address bits 0..17
  localparam int DATA_W      = 36;     // Data word width
  localparam int MASK_W      = 2;      // One mask bit per data half
  localparam int ROW_W       = 13;     // Internal refresh row counter
  localparam int BANKS       = 8;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_RESET = 18'h0_0000;
  localparam logic [1:0] BURST_LEN_DEF = 2'h1;       // Burst of four words
  localparam int CLK_PERIOD_NS       = 10;
  localparam int CONFIG_SETTLE_NS    = 60;           // Mode settle time
  localparam int CONFIG_SETTLE_CYC   =
    (CONFIG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_GROUP_NS    = 3900;         // Group posting period
  localparam int REFRESH_GROUP_CYC   = REFRESH_GROUP_NS / CLK_PERIOD_NS;
  localparam int MODE_BL_LSB         = 3;            // Burst length field

  // ----------------------------------------------------------------
  // Decoded command set
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    deselect_idle_cmd,
    config_load_cmd,
    read_cmd,
    write_cmd,
    bank_refresh_cmd,
    illegal_cmd
  } cmd_t;
endpackage : cmd_decode_pkg

// file: src/mem_cmd_controller.sv
module mem_cmd_controller
  import cmd_decode_pkg::*;
#(
  parameter int REFRESH_CYC = REFRESH_GROUP_CYC   // Group period in cycles
) (
  input  wire logic              clk,
  input  wire logic              reset,
  mem_cmd_if.controller          link,
  input  wire logic              req_valid,   // User request, level
  input  wire cmd_t              req_cmd,     // Read, write or config load
  input  wire logic [BANK_W-1:0] req_bank,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [MASK_W-1:0] req_mask,
  output logic                   req_ready,   // Request taken this edge
  output logic [DATA_W-1:0]      rd_data,
  output logic                   rd_valid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]        settle;     // Settle countdown after mode load
    logic [31:0]       ref_timer;  // Cycles to next refresh group
    logic [3:0]        ref_left;   // Refreshes still to post
    logic [3:0]        busy;       // Burst words still running
    logic              sel_n;
    logic              write_n;
    logic              refresh_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [MASK_W-1:0] mask;
    logic              ready;
    logic [DATA_W-1:0] rd_data;
    logic              rd_valid;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Refresh group wins over user work; mode load waits for idle
  always_comb begin
    state_next          = state_reg;
    state_next.sel_n    = 1'b1;           // Idle by default
    state_next.write_n  = 1'b1;
    state_next.refresh_n = 1'b1;
    state_next.ready    = 1'b0;
    state_next.rd_data  = link.rdata;
    state_next.rd_valid = link.rvalid;
    state_next.mask     = '1;
    if (state_reg.settle != 4'h0) state_next.settle = state_reg.settle - 4'h1;
    if (state_reg.busy != 4'h0) state_next.busy = state_reg.busy - 4'h1;
    if (state_reg.ref_timer != 32'h0000_0000) begin
      state_next.ref_timer = state_reg.ref_timer - 32'h0000_0001;
    end

    if (state_reg.settle != 4'h0 || state_reg.busy > 4'h1) begin
      // Hold off while settling or while more than one burst word is left
    end else if (state_reg.ref_left != 4'h0) begin
      // Post one refresh per bank on consecutive cycles
      state_next.sel_n     = 1'b0;
      state_next.refresh_n = 1'b0;
      state_next.bank      = BANK_W'(BANKS - 4'(state_reg.ref_left));
      state_next.ref_left  = state_reg.ref_left - 4'h1;
    end else if (state_reg.ref_timer == 32'h0000_0000) begin
      state_next.ref_left  = 4'(BANKS);
      state_next.ref_timer = 32'(REFRESH_CYC);
    end else if (req_valid && !state_reg.ready &&
                 !(req_cmd == config_load_cmd &&
                   (state_reg.busy != 4'h0 || link.rvalid))) begin
      // Mode load waits until no read word is left; a write longer than
      // four words is not tracked here
      state_next.ready = 1'b1;
      state_next.sel_n = 1'b0;
      state_next.bank  = req_bank;
      state_next.addr  = req_addr;
      case (req_cmd)
        config_load_cmd: begin
          state_next.write_n   = 1'b0;
          state_next.refresh_n = 1'b0;
          state_next.settle    = 4'(CONFIG_SETTLE_CYC);
          state_next.busy      = 4'h0;
        end
        write_cmd: begin
          state_next.write_n = 1'b0;
          state_next.wdata   = req_wdata;
          state_next.mask    = req_mask;
          state_next.busy    = 4'h4;
        end
        default: begin
          state_next.busy = 4'h4;                           // Read
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg           <= '0;
      state_reg.sel_n     <= 1'b1;
      state_reg.write_n   <= 1'b1;
      state_reg.refresh_n <= 1'b1;
      state_reg.mask      <= '1;
      state_reg.ref_timer <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.sel_n       = state_reg.sel_n;
  assign link.write_n     = state_reg.write_n;
  assign link.refresh_n   = state_reg.refresh_n;
  assign link.bank_select = state_reg.bank;
  assign link.addr        = state_reg.addr;
  assign link.wdata       = state_reg.wdata;
  assign link.write_mask  = state_reg.mask;
  assign req_ready        = state_reg.ready;
  assign rd_data          = state_reg.rd_data;
  assign rd_valid         = state_reg.rd_valid;

endmodule // mem_cmd_controller

// file: src/mem_cmd_device.sv
module mem_cmd_device
  import cmd_decode_pkg::*;
#(
  parameter int DEPTH_W = 4            // Stored locations per bank (2**DEPTH_W)
) (
  input  wire logic        clk,
  input  wire logic        reset,
  mem_cmd_if.device        link,
  output logic [MODE_W-1:0] mode_word,     // Current mode register
  output logic [2:0]       busy_banks_cnt, // Burst words still to move (low bits)
  output logic             illegal_seen,   // Sticky: undefined command decoded
  output logic [ROW_W-1:0] last_refresh_row,
  output logic [BANK_W-1:0] last_refresh_bank
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int LOCS = 1 << DEPTH_W;
  // Only the low DEPTH_W address bits reach storage; the rest of the
  // read and write address is accepted but not kept, which keeps the
  // flip-flop array small

  // Kind of burst in flight; only one runs at a time
  typedef enum logic [1:0] {burst_idle, burst_read, burst_write} burst_t;

  // Whole control state in one packed word, so one process computes it
  // and one register stage holds it
  typedef struct packed {
    logic [MODE_W-1:0]                   mode;       // Mode register
    burst_t                              burst;      // Running burst kind
    logic [BANK_W-1:0]                   bank;       // Burst bank
    logic [DEPTH_W-1:0]                  loc;        // Burst location
    logic [3:0]                          left;       // Words still to move
    logic [BANKS-1:0][ROW_W-1:0]         row;        // Refresh row per bank
    logic [ROW_W-1:0]                    ref_row;
    logic [BANK_W-1:0]                   ref_bank;
    logic                                illegal;
    logic [DATA_W-1:0]                   rdata;
    logic                                rvalid;
  } state_t;

  // Registered state and its next value
  state_t state_reg;
  state_t state_next;
  // Storage stays apart from the packed state: it would make the state
  // word very wide, and it needs no reset
  logic [DATA_W-1:0] mem_reg [BANKS][LOCS];  // Array, flip-flops
  // Decode and write-port helpers
  cmd_t              cmd;                    // Decoded command this edge
  logic [3:0]        burst_words;            // Words per burst from mode
  logic              wr_beat;                // Write word taken this edge
  logic [BANK_W-1:0] wr_bank;
  logic [DEPTH_W-1:0] wr_loc;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Pure decode of the strobes as seen at this rising edge
  always_comb begin
    if (link.sel_n) begin
      cmd = deselect_idle_cmd;
    end else begin
      // Write strobe is the upper bit; all four codes are defined
      case ({link.write_n, link.refresh_n})
        2'b00:   cmd = config_load_cmd;
        2'b11:   cmd = read_cmd;
        2'b01:   cmd = write_cmd;
        2'b10:   cmd = bank_refresh_cmd;
        // Unreachable with two strobes; kept so the decode stays total
        default: cmd = illegal_cmd;
      endcase
    end
  end

  // Burst length field: 0 -> 2, 1 -> 4, 2 -> 8 words
  // Code 3 is undefined; four words is the safe fallback, since the
  // controller spaces its commands for a four-word burst
  always_comb begin
    case (state_reg.mode[MODE_BL_LSB +: 2])
      2'h0:    burst_words = 4'h2;
      2'h2:    burst_words = 4'h8;
      default: burst_words = 4'h4;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One process holds the whole sequence; memory write is separate
  // A new read or write replaces any burst still in flight
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;
    wr_beat           = 1'b0;
    wr_bank           = state_reg.bank;
    wr_loc            = state_reg.loc;

    // Ongoing burst advances whatever is decoded this edge
    if (state_reg.burst != burst_idle) begin
      // Read word leaves through a register, one edge later
      if (state_reg.burst == burst_read) begin
        state_next.rdata  = mem_reg[state_reg.bank][state_reg.loc];
        state_next.rvalid = 1'b1;
      end else begin
        // Later write words come from the data lines at this edge
        wr_beat = 1'b1;
      end
      state_next.loc  = state_reg.loc + DEPTH_W'(1);
      state_next.left = state_reg.left - 4'h1;
      // Last word moved: the burst ends here
      if (state_reg.left == 4'h1) begin
        state_next.burst = burst_idle;
      end
    end

    case (cmd)
      deselect_idle_cmd: begin
        // Nothing accepted; running burst already handled
      end
      config_load_cmd: begin
        // Upper address bits and the bank select are dropped
        state_next.mode = link.addr[MODE_W-1:0];
      end
      read_cmd, write_cmd: begin
        // A new burst takes over; controller spaces commands for a four-word burst
        state_next.burst = (cmd == read_cmd) ? burst_read : burst_write;
        state_next.bank  = link.bank_select;
        state_next.loc   = link.addr[DEPTH_W-1:0];
        state_next.left  = burst_words;
        if (cmd == write_cmd) begin
          // First word rides with the command itself
          wr_beat          = 1'b1;
          wr_bank          = link.bank_select;
          wr_loc           = link.addr[DEPTH_W-1:0];
          // Next word goes to the following location
          state_next.loc   = link.addr[DEPTH_W-1:0] + DEPTH_W'(1);
          state_next.left  = burst_words - 4'h1;
        end
      end
      bank_refresh_cmd: begin
        // Row from internal counter; address pins are ignored
        state_next.ref_bank = link.bank_select;
        // Report the row about to be refreshed, then step its counter
        state_next.ref_row  = state_reg.row[link.bank_select];
        // Row counter wraps, so every row of a bank comes round again
        state_next.row[link.bank_select] =
          state_reg.row[link.bank_select] + ROW_W'(1);
      end
      default: begin
        // Undefined strobe code: remembered for the user
        state_next.illegal = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // All control state on one edge of clk
  // Reset clears every field, then gives the mode register its value
  // No command is decoded while reset is high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg      <= '0;
      state_reg.mode <= MODE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Array writes with per-half masking; no reset on storage
  // A mask bit high leaves that half of the stored word unchanged
  always_ff @(posedge clk) begin
    if (wr_beat) begin
      for (int h = 0; h < MASK_W; h++) begin
        if (!link.write_mask[h]) begin
          mem_reg[wr_bank][wr_loc][h*(DATA_W/MASK_W) +: DATA_W/MASK_W] <=
            link.wdata[h*(DATA_W/MASK_W) +: DATA_W/MASK_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a state field, so none is combinational
  // Link outputs
  assign link.rdata        = state_reg.rdata;
  assign link.rvalid       = state_reg.rvalid;
  // Status outputs; busy_banks_cnt shows the low three bits only, so an
  // eight-word read burst reads as zero until its first word has moved
  assign mode_word         = state_reg.mode;
  assign busy_banks_cnt    = state_reg.left[2:0];
  assign illegal_seen      = state_reg.illegal;
  assign last_refresh_row  = state_reg.ref_row;
  assign last_refresh_bank = state_reg.ref_bank;

endmodule // mem_cmd_device

// file: src/mem_cmd_if.sv
interface mem_cmd_if;
  import cmd_decode_pkg::*;
  logic                 sel_n;      // Chip select, active low
  logic                 write_n;    // Write strobe, active low
  logic                 refresh_n;  // Refresh strobe, active low
  logic [BANK_W-1:0]    bank_select;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata;
  logic [MASK_W-1:0]    write_mask;
  logic [DATA_W-1:0]    rdata;
  logic                 rvalid;

  modport device (
    input  sel_n, write_n, refresh_n, bank_select, addr, wdata, write_mask,
    output rdata, rvalid
  );
  modport controller (
    output sel_n, write_n, refresh_n, bank_select, addr, wdata, write_mask,
    input  rdata, rvalid
  );
endinterface : mem_cmd_if
